/* rtl/aof_formatter.sv */
`timescale 1ns/10ps
`include "aof_cfg.svh"

module aof_formatter (
    // sample clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // link clock
    input wire logic link_clk_in,
    // converter samples, offset binary, lane n at [14n+13:14n]
    input wire logic [111:0] sample_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // pin strap
    input wire logic fixed_pattern_strap_in,
    // driver controls
    output logic lvds_reduced_out,
    output logic [7:0] drive_strength_out,
    output logic [2:0] bit_clock_phase_out,
    // link, ddr halves
    output logic [7:0] lane_first_out,
    output logic [7:0] lane_second_out,
    output logic bit_clock_out_first,
    output logic bit_clock_out_second,
    output logic frame_clock_out_first,
    output logic frame_clock_out_second
);
    import aof_pkg::*;

    // register file
    logic [7:0] test_mode_q;
    logic [7:0] out_mode_q;
    logic [7:0] output_drive_strength_q;
    logic [7:0] phase_q;
    logic [7:0] user_pattern_one_part_a_q;
    logic [7:0] user_pattern_one_part_b_q;
    logic [7:0] user_pattern_two_part_a_q;
    logic [7:0] user_pattern_two_part_b_q;
    logic [7:0] resolution_q;
    logic [7:0] rdata_d;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            test_mode_q <= `AOF_TEST_MODE_RST;
            out_mode_q <= `AOF_OUT_MODE_RST;
            output_drive_strength_q <= `AOF_DRIVE_RST;
            phase_q <= `AOF_PHASE_RST;
            user_pattern_one_part_a_q <= `AOF_USER_RST;
            user_pattern_one_part_b_q <= `AOF_USER_RST;
            user_pattern_two_part_a_q <= `AOF_USER_RST;
            user_pattern_two_part_b_q <= `AOF_USER_RST;
            resolution_q <= `AOF_RESOLUTION_RST;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `AOF_ADDR_TEST_MODE: test_mode_q <= reg_wdata_in;
                `AOF_ADDR_OUT_MODE: out_mode_q <= reg_wdata_in;
                `AOF_ADDR_DRIVE: output_drive_strength_q <= reg_wdata_in;
                `AOF_ADDR_PHASE: phase_q <= reg_wdata_in;
                `AOF_ADDR_USER1_A: user_pattern_one_part_a_q <= reg_wdata_in;
                `AOF_ADDR_USER1_B: user_pattern_one_part_b_q <= reg_wdata_in;
                `AOF_ADDR_USER2_A: user_pattern_two_part_a_q <= reg_wdata_in;
                `AOF_ADDR_USER2_B: user_pattern_two_part_b_q <= reg_wdata_in;
                `AOF_ADDR_RESOLUTION: resolution_q <= reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    // strap, synchronised then caught once after reset release
    logic strap_s1_q;
    logic strap_s2_q;
    logic strap_q;
    logic strap_done_q;

    always_ff @(posedge clk_in) begin
        strap_s1_q <= fixed_pattern_strap_in;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_q <= strap_s2_q;
            strap_done_q <= 1'b1;
        end
    end

    // effective controls
    logic [3:0] mode_eff;
    logic res12;
    logic twos;
    logic lsb_first;

    always_comb begin
        mode_eff = test_mode_q[3:0];
        if (strap_q && test_mode_q[3:0] == AOF_TM_OFF) begin
            mode_eff = AOF_TM_ONE_BIT_HIGH;
        end
    end

    assign res12 = resolution_q[`AOF_RES_12BIT_BIT];
    assign twos = out_mode_q[`AOF_OM_FORMAT_BIT];
    assign lsb_first = out_mode_q[`AOF_OM_LSB_FIRST_BIT];

    // read back; test mode shows the mode actually in force
    always_comb begin
        unique case (reg_addr_in)
            `AOF_ADDR_TEST_MODE: rdata_d = {test_mode_q[7:4], mode_eff};
            `AOF_ADDR_OUT_MODE: rdata_d = out_mode_q;
            `AOF_ADDR_DRIVE: rdata_d = output_drive_strength_q;
            `AOF_ADDR_PHASE: rdata_d = phase_q;
            `AOF_ADDR_USER1_A: rdata_d = user_pattern_one_part_a_q;
            `AOF_ADDR_USER1_B: rdata_d = user_pattern_one_part_b_q;
            `AOF_ADDR_USER2_A: rdata_d = user_pattern_two_part_a_q;
            `AOF_ADDR_USER2_B: rdata_d = user_pattern_two_part_b_q;
            `AOF_ADDR_RESOLUTION: rdata_d = resolution_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
            lvds_reduced_out <= 1'b0;
            drive_strength_out <= `AOF_DRIVE_RST;
            bit_clock_phase_out <= 3'(`AOF_PHASE_RST);
        end else begin
            reg_rdata_out <= rdata_d;
            lvds_reduced_out <= out_mode_q[`AOF_OM_REDUCED_BIT];
            drive_strength_out <= output_drive_strength_q;
            bit_clock_phase_out <= phase_q[2:0];
        end
    end

    // test pattern source
    aof_word_t pat_word;
    logic pat_dep;

    aof_pattern_gen u_pattern (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .mode_in(mode_eff),
        .res12_in(res12),
        .pn_long_rst_in(test_mode_q[`AOF_TM_PN_LONG_RST_BIT]),
        .pn_short_rst_in(test_mode_q[`AOF_TM_PN_SHORT_RST_BIT]),
        .user_one_in(aof_word_t'({user_pattern_one_part_b_q,
            user_pattern_one_part_a_q} >> 2)),
        .user_two_in(aof_word_t'({user_pattern_two_part_b_q,
            user_pattern_two_part_a_q} >> 2)),
        .word_out(pat_word),
        .fmt_dep_out(pat_dep)
    );

    // per lane: select, recode, order
    logic test_on_q;
    logic [111:0] conv_q;
    logic [111:0] lane_word;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            test_on_q <= 1'b0;
            conv_q <= '0;
        end else begin
            test_on_q <= (mode_eff != AOF_TM_OFF);
            conv_q <= sample_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lane
            aof_word_t src;
            aof_word_t coded;
            aof_word_t rev;
            logic dep;
            always_comb begin
                src = test_on_q ? pat_word : conv_q[14*g +: 14];
                dep = test_on_q ? pat_dep : 1'b1;
                if (res12) begin
                    src = src & `AOF_W_LOW2_MASK;
                end
                coded = src;
                if (twos && dep) begin
                    coded = src ^ `AOF_W_MSB_MASK;
                end
                rev = 14'h0000;
                for (int b = 0; b < 14; b++) begin
                    rev[b] = coded[13 - b];
                end
                if (res12) begin
                    rev = {rev[11:0], 2'b00};
                end
                lane_word[14*g +: 14] = lsb_first ? rev : coded;
            end
        end
    endgenerate

    // word handshake into the link domain
    logic [111:0] bundle_q;
    logic req_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_q;

    always_ff @(posedge clk_in) begin
        ack_s1_q <= ack_q;
        ack_s2_q <= ack_s1_q;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bundle_q <= '0;
            req_q <= 1'b0;
        end else if (ack_s2_q == req_q) begin
            bundle_q <= lane_word;
            req_q <= ~req_q;
        end
    end

    // link domain reset and config
    logic lrst_s1_q;
    logic link_rst_q;
    logic res_s1_q;
    logic res_s2_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic [111:0] pending_q;

    always_ff @(posedge link_clk_in) begin
        lrst_s1_q <= srst_in;
        link_rst_q <= lrst_s1_q;
        res_s1_q <= res12;
        res_s2_q <= res_s1_q;
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
    end

    always_ff @(posedge link_clk_in) begin
        if (link_rst_q) begin
            req_s3_q <= 1'b0;
            ack_q <= 1'b0;
            pending_q <= '0;
        end else begin
            req_s3_q <= req_s2_q;
            if (req_s2_q != req_s3_q) begin
                pending_q <= bundle_q;
                ack_q <= req_s2_q;
            end
        end
    end

    // word framing on the link clock
    logic [2:0] cyc_q;
    logic [2:0] cyc_d;
    logic [2:0] last_cyc;
    logic [2:0] rise_max;
    logic load;

    assign last_cyc = res_s2_q ? `AOF_LAST_CYC_12 : `AOF_LAST_CYC_14;
    assign rise_max = res_s2_q ? `AOF_FRAME_RISE_MAX_12
                               : `AOF_FRAME_RISE_MAX_14;
    assign load = (cyc_q >= last_cyc);
    assign cyc_d = load ? 3'h0 : cyc_q + 3'h1;

    always_ff @(posedge link_clk_in) begin
        if (link_rst_q) begin
            cyc_q <= 3'h0;
        end else begin
            cyc_q <= cyc_d;
        end
    end

    // frame halves registered on the same edge as the lane bits
    always_ff @(posedge link_clk_in) begin
        if (link_rst_q) begin
            frame_clock_out_first <= 1'b0;
            frame_clock_out_second <= 1'b0;
            bit_clock_out_first <= 1'b0;
            bit_clock_out_second <= 1'b0;
        end else begin
            frame_clock_out_first <= (cyc_d <= rise_max);
            frame_clock_out_second <= (cyc_d <= `AOF_FRAME_FALL_MAX);
            bit_clock_out_first <= 1'b1;
            bit_clock_out_second <= 1'b0;
        end
    end

    generate
        for (g = 0; g < 8; g++) begin : g_ser
            aof_lane_ser u_ser (
                .link_clk_in(link_clk_in),
                .link_rst_in(link_rst_q),
                .load_in(load),
                .word_in(pending_q[14*g +: 14]),
                .bit_first_out(lane_first_out[g]),
                .bit_second_out(lane_second_out[g])
            );
        end
    endgenerate

endmodule

/* rtl/aof_cfg.svh */
`ifndef AOF_CFG_SVH
`define AOF_CFG_SVH

// register offsets
`define AOF_ADDR_TEST_MODE 8'h0D
`define AOF_ADDR_OUT_MODE 8'h14
`define AOF_ADDR_DRIVE 8'h15
`define AOF_ADDR_PHASE 8'h16
`define AOF_ADDR_USER1_A 8'h19
`define AOF_ADDR_USER1_B 8'h1A
`define AOF_ADDR_USER2_A 8'h1B
`define AOF_ADDR_USER2_B 8'h1C
`define AOF_ADDR_RESOLUTION 8'h21

// field positions
`define AOF_TM_PN_LONG_RST_BIT 4
`define AOF_TM_PN_SHORT_RST_BIT 5
`define AOF_OM_FORMAT_BIT 0
`define AOF_OM_REDUCED_BIT 1
`define AOF_OM_LSB_FIRST_BIT 2
`define AOF_RES_12BIT_BIT 0

// reset values
`define AOF_TEST_MODE_RST 8'h00
`define AOF_OUT_MODE_RST 8'h01
`define AOF_DRIVE_RST 8'h00
`define AOF_PHASE_RST 8'h03
`define AOF_USER_RST 8'h00
`define AOF_RESOLUTION_RST 8'h00

// pattern words and masks, msb aligned in 14 bits, then the 9 and 23 bit prbs seeds
`define AOF_W_MID 14'h2000
`define AOF_W_POS_FS 14'h3FFF
`define AOF_W_NEG_FS 14'h0000
`define AOF_W_CHECK_A 14'h2AAA
`define AOF_W_CHECK_B 14'h1555
`define AOF_W_SYNC14 14'h007F
`define AOF_W_SYNC12 14'h00FC
`define AOF_W_MIXED14 14'h2867
`define AOF_W_MIXED12 14'h28CC
`define AOF_W_MSB_MASK 14'h2000
`define AOF_W_LOW2_MASK 14'h3FFC
`define AOF_PN9_SEED 9'h1FF
`define AOF_PN23_SEED 23'h7FFFFF

// link timing, in bit clock cycles
`define AOF_LAST_CYC_14 3'h6
`define AOF_LAST_CYC_12 3'h5
`define AOF_FRAME_RISE_MAX_14 3'h3
`define AOF_FRAME_RISE_MAX_12 3'h2
`define AOF_FRAME_FALL_MAX 3'h2

`endif

/* rtl/aof_pkg.sv */
package aof_pkg;

    typedef logic [13:0] aof_word_t;

    typedef enum logic [3:0] {
        AOF_TM_OFF = 4'b0000,
        AOF_TM_MIDSCALE = 4'b0001,
        AOF_TM_POS_FS = 4'b0010,
        AOF_TM_NEG_FS = 4'b0011,
        AOF_TM_CHECKER = 4'b0100,
        AOF_TM_PN_LONG = 4'b0101,
        AOF_TM_PN_SHORT = 4'b0110,
        AOF_TM_WORD_TOGGLE = 4'b0111,
        AOF_TM_USER = 4'b1000,
        AOF_TM_BIT_TOGGLE = 4'b1001,
        AOF_TM_SYNC = 4'b1010,
        AOF_TM_ONE_BIT_HIGH = 4'b1011,
        AOF_TM_MIXED = 4'b1100
    } aof_test_e;

endpackage

/* rtl/aof_pattern_gen.sv */
`timescale 1ns/10ps
`include "aof_cfg.svh"

module aof_pattern_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic [3:0] mode_in,
    input wire logic res12_in,
    input wire logic pn_long_rst_in,
    input wire logic pn_short_rst_in,
    input wire aof_pkg::aof_word_t user_one_in,
    input wire aof_pkg::aof_word_t user_two_in,
    // pattern
    output aof_pkg::aof_word_t word_out,
    output logic fmt_dep_out
);
    import aof_pkg::*;

    logic [8:0] pn9_q;
    logic [8:0] pn9_d;
    logic [22:0] pn23_q;
    logic [22:0] pn23_d;
    aof_word_t pn9_word;
    aof_word_t pn23_word;
    logic alt_q;
    aof_word_t word_d;
    logic dep_d;

    // fourteen serial steps per sample, msb first
    always_comb begin
        pn9_d = pn9_q;
        pn23_d = pn23_q;
        pn9_word = 14'h0000;
        pn23_word = 14'h0000;
        for (int i = 13; i >= 0; i--) begin
            pn9_word[i] = pn9_d[8];
            pn9_d = {pn9_d[7:0], pn9_d[8] ^ pn9_d[4]};
            pn23_word[i] = ~pn23_d[22];
            pn23_d = {pn23_d[21:0], pn23_d[22] ^ pn23_d[17]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || pn_short_rst_in) begin
            pn9_q <= `AOF_PN9_SEED;
        end else if (mode_in == AOF_TM_PN_SHORT) begin
            pn9_q <= pn9_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || pn_long_rst_in) begin
            pn23_q <= `AOF_PN23_SEED;
        end else if (mode_in == AOF_TM_PN_LONG) begin
            pn23_q <= pn23_d;
        end
    end

    // word one and word two alternate on consecutive samples
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            alt_q <= 1'b0;
        end else begin
            alt_q <= ~alt_q;
        end
    end

    always_comb begin
        word_d = 14'h0000;
        dep_d = 1'b1;
        unique case (mode_in)
            AOF_TM_MIDSCALE: word_d = `AOF_W_MID;
            AOF_TM_POS_FS: word_d = `AOF_W_POS_FS;
            AOF_TM_NEG_FS: word_d = `AOF_W_NEG_FS;
            AOF_TM_PN_LONG: word_d = pn23_word;
            AOF_TM_PN_SHORT: word_d = pn9_word;
            AOF_TM_CHECKER: begin
                word_d = alt_q ? `AOF_W_CHECK_B : `AOF_W_CHECK_A;
                dep_d = 1'b0;
            end
            AOF_TM_WORD_TOGGLE: begin
                word_d = alt_q ? `AOF_W_NEG_FS : `AOF_W_POS_FS;
                dep_d = 1'b0;
            end
            AOF_TM_USER: begin
                word_d = alt_q ? user_two_in : user_one_in;
                dep_d = 1'b0;
            end
            AOF_TM_BIT_TOGGLE: begin
                word_d = `AOF_W_CHECK_A;
                dep_d = 1'b0;
            end
            AOF_TM_SYNC: begin
                word_d = res12_in ? `AOF_W_SYNC12 : `AOF_W_SYNC14;
                dep_d = 1'b0;
            end
            AOF_TM_ONE_BIT_HIGH: begin
                word_d = `AOF_W_MID;
                dep_d = 1'b0;
            end
            AOF_TM_MIXED: begin
                word_d = res12_in ? `AOF_W_MIXED12 : `AOF_W_MIXED14;
                dep_d = 1'b0;
            end
            default: word_d = 14'h0000;
        endcase
        if (res12_in) begin
            word_d = word_d & `AOF_W_LOW2_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            word_out <= 14'h0000;
            fmt_dep_out <= 1'b1;
        end else begin
            word_out <= word_d;
            fmt_dep_out <= dep_d;
        end
    end

endmodule

/* rtl/aof_lane_ser.sv */
`timescale 1ns/10ps
`include "aof_cfg.svh"

module aof_lane_ser (
    // link clock and reset
    input wire logic link_clk_in,
    input wire logic link_rst_in,
    // word load
    input wire logic load_in,
    input wire aof_pkg::aof_word_t word_in,
    // ddr halves, first half then second half
    output logic bit_first_out,
    output logic bit_second_out
);
    import aof_pkg::*;

    aof_word_t shift_q;

    // two bits leave per link cycle, both on the rising edge
    always_ff @(posedge link_clk_in) begin
        if (link_rst_in) begin
            shift_q <= 14'h0000;
            bit_first_out <= 1'b0;
            bit_second_out <= 1'b0;
        end else if (load_in) begin
            bit_first_out <= word_in[13];
            bit_second_out <= word_in[12];
            shift_q <= {word_in[11:0], 2'b00};
        end else begin
            bit_first_out <= shift_q[13];
            bit_second_out <= shift_q[12];
            shift_q <= {shift_q[11:0], 2'b00};
        end
    end

endmodule

/* test/aof_formatter_chk.sv */
`timescale 1ns/10ps
module aof_formatter_chk (
    // sample domain
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic lvds_reduced_out,
    input wire logic [7:0] drive_strength_out,
    input wire logic [2:0] bit_clock_phase_out,
    // link domain
    input wire logic link_clk_in,
    input wire logic bit_clock_out_first,
    input wire logic bit_clock_out_second,
    input wire logic frame_clock_out_first,
    input wire logic frame_clock_out_second
);
    logic [3:0] run_q;
    logic up;

    // link outputs lag reset release by a few edges
    always_ff @(posedge link_clk_in) begin
        if (srst_in) begin
            run_q <= 4'h0;
        end else if (run_q != 4'hF) begin
            run_q <= run_q + 4'h1;
        end
    end
    assign up = (run_q == 4'hF);

    a_drive_write: assert property (
        @(posedge clk_in) disable iff (srst_in)
        reg_wr_in && reg_addr_in == 8'h15 |-> ##2
        drive_strength_out == $past(reg_wdata_in, 2))
        else $error("drive strength not taken from write");
    a_phase_write: assert property (
        @(posedge clk_in) disable iff (srst_in)
        reg_wr_in && reg_addr_in == 8'h16 |-> ##2
        bit_clock_phase_out == $past(reg_wdata_in[2:0], 2))
        else $error("bit clock phase not taken from write");
    a_swing_write: assert property (
        @(posedge clk_in) disable iff (srst_in)
        reg_wr_in && reg_addr_in == 8'h14 |-> ##2
        lvds_reduced_out == $past(reg_wdata_in[1], 2))
        else $error("reduced swing not taken from write");
    a_phase_read: assert property (
        @(posedge clk_in) disable iff (srst_in)
        reg_addr_in == 8'h16 && !reg_wr_in |=>
        reg_rdata_out[2:0] == bit_clock_phase_out)
        else $error("phase readback differs from output");
    a_reset_defaults: assert property (
        @(posedge clk_in) disable iff (srst_in)
        $fell(srst_in) |-> bit_clock_phase_out == 3'h3 && !lvds_reduced_out)
        else $error("wrong driver defaults after reset");
    a_bit_clock_wave: assert property (
        @(posedge link_clk_in) disable iff (srst_in)
        up |-> bit_clock_out_first && !bit_clock_out_second)
        else $error("bit clock halves wrong");
    a_frame_shape: assert property (
        @(posedge link_clk_in) disable iff (srst_in)
        up && $rose(frame_clock_out_first) |->
        frame_clock_out_second [*3] ##1 !frame_clock_out_second)
        else $error("frame second half wrong length");
    a_frame_period: assert property (
        @(posedge link_clk_in) disable iff (srst_in)
        up && $rose(frame_clock_out_first) |->
        ##[6:7] $rose(frame_clock_out_first))
        else $error("frame period not 6 or 7 link cycles");
    a_frame_halves: assert property (
        @(posedge link_clk_in) disable iff (srst_in)
        up && frame_clock_out_second |-> frame_clock_out_first)
        else $error("frame second half high without first");

    c_mode_write: cover property (@(posedge clk_in)
        reg_wr_in && reg_addr_in == 8'h0D);
    c_res_write: cover property (@(posedge clk_in)
        reg_wr_in && reg_addr_in == 8'h21);
    c_frame: cover property (@(posedge link_clk_in)
        up && $rose(frame_clock_out_first));
endmodule

/* test/aof_rx_model.sv */
`timescale 1ns/10ps
module aof_rx_model (
    // link from the formatter
    input wire logic link_clk_in,
    input wire logic [7:0] lane_first_in,
    input wire logic [7:0] lane_second_in,
    input wire logic frame_first_in,
    // captured words, lane n at [14n+13:14n], right aligned
    output logic [111:0] words_out,
    output logic [4:0] bits_out,
    output logic [15:0] count_out
);
    logic [111:0] acc_q = '0;
    logic [4:0] cnt_q = 5'h00;
    logic frame_q = 1'b0;
    logic start;

    initial begin
        words_out = '0;
        bits_out = 5'h00;
        count_out = 16'h0000;
    end
    assign start = frame_first_in && !frame_q;

    // both halves of every bit clock cycle carry a bit
    // sampled mid-cycle, away from the launching edge
    always @(negedge link_clk_in) begin
        frame_q <= frame_first_in;
        for (int l = 0; l < 8; l++) begin
            if (start) begin
                acc_q[l*14 +: 14] <= {12'h000, lane_first_in[l],
                                      lane_second_in[l]};
            end else begin
                acc_q[l*14 +: 14] <= {acc_q[l*14 +: 12], lane_first_in[l],
                                      lane_second_in[l]};
            end
        end
        if (start) begin
            words_out <= acc_q;
            bits_out <= cnt_q;
            count_out <= count_out + 16'h0001;
            cnt_q <= 5'h02;
        end else begin
            cnt_q <= cnt_q + 5'h02;
        end
    end
endmodule

/* test/aof_formatter_bench.sv */
`timescale 1ns/10ps
module aof_formatter_bench;
    import aof_pkg::*;
    localparam logic [13:0] SV [8] = '{14'h0000, 14'h2000, 14'h3FFF,
        14'h1234, 14'h0ABC, 14'h3C3C, 14'h1001, 14'h2FFE};
    localparam logic [7:0] RA [10] = '{8'h0D, 8'h14, 8'h15, 8'h16, 8'h19,
        8'h1A, 8'h1B, 8'h1C, 8'h21, 8'h30};
    localparam logic [7:0] RV [10] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] TM [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A,
        8'h0B, 8'h0C};
    localparam logic [13:0] TW [7] = '{14'h0000, 14'h1FFF, 14'h2000,
        14'h2AAA, 14'h007F, 14'h2000, 14'h2867};
    localparam logic [7:0] AM [3] = '{8'h04, 8'h07, 8'h08};
    localparam logic [13:0] AW [3] = '{14'h2AAA, 14'h3FFF, 14'h30D7};
    localparam logic [13:0] BW [3] = '{14'h1555, 14'h0000, 14'h03C3};
    localparam logic [7:0] PM [2] = '{8'h06, 8'h05};
    localparam logic [7:0] PH [2] = '{8'h20, 8'h10};
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [111:0] sample_in;
    logic [111:0] rx_words;
    logic [7:0] reg_rdata_out, drive_strength_out;
    logic [7:0] lane_first_out, lane_second_out;
    logic lvds_reduced_out, bit_clock_out_first, bit_clock_out_second;
    logic frame_clock_out_first, frame_clock_out_second;
    logic [2:0] bit_clock_phase_out;
    logic [4:0] rx_bits;
    logic [15:0] rx_count;
    int mismatches = 0;
    int num_checks = 0;

    always #12.5 clk_in = ~clk_in;
    always #6 link_clk_in = ~link_clk_in;

    aof_formatter DUT (.clk_in, .srst_in, .link_clk_in, .sample_in, .reg_wr_in,
        .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
        .fixed_pattern_strap_in(1'b0), .lvds_reduced_out, .drive_strength_out,
        .bit_clock_phase_out, .lane_first_out, .lane_second_out,
        .bit_clock_out_first, .bit_clock_out_second, .frame_clock_out_first,
        .frame_clock_out_second);
    aof_rx_model u_rx (.link_clk_in, .lane_first_in(lane_first_out),
        .lane_second_in(lane_second_out),
        .frame_first_in(frame_clock_out_first),
        .words_out(rx_words), .bits_out(rx_bits), .count_out(rx_count));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask

    // wait until the receiver has framed n more words
    task automatic words(input int n);
        logic [15:0] c0;
        c0 = rx_count;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_in);
            if (rx_count - c0 >= 16'(n)) return;
        end
        mismatches++;
        stop_test();
    endtask

    // six frames cover the handshake, framing and receiver latency
    task automatic lanes(input logic [13:0] e, input logic [4:0] nb);
        words(6);
        check(rx_bits, nb);
        for (int l = 0; l < 8; l++) begin
            check(rx_words[l*14 +: 14], e);
        end
    endtask

    task automatic samp(input logic [13:0] flip);
        words(6);
        for (int l = 0; l < 8; l++) begin
            check(rx_words[l*14 +: 14], SV[l] ^ flip);
        end
    endtask

    initial begin
        logic [7:0] d;
        logic [13:0] a;
        logic hit;
        for (int l = 0; l < 8; l++) sample_in[l*14 +: 14] = SV[l];
        repeat (8) @(negedge clk_in);
        srst_in = 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(RA[i], d);
            check(d, RV[i]);
        end
        check(lvds_reduced_out, 1'b0);
        check(bit_clock_phase_out, 3'h3);
        wr(8'h15, 8'hA5);
        wr(8'h16, 8'h05);
        wr(8'h14, 8'h03);
        wr(8'h30, 8'hFF);
        rd(8'h30, d);
        check(d, 8'h00);
        check(drive_strength_out, 8'hA5);
        check(bit_clock_phase_out, 3'h5);
        check(lvds_reduced_out, 1'b1);
        samp(14'h2000);
        wr(8'h14, 8'h02);
        samp(14'h0000);
        wr(8'h14, 8'h03);
        for (int i = 0; i < 7; i++) begin
            wr(8'h0D, TM[i]);
            lanes(TW[i], 5'h0E);
        end
        wr(8'h19, 8'h5C);
        wr(8'h1A, 8'hC3);
        wr(8'h1B, 8'h0C);
        wr(8'h1C, 8'h0F);
        for (int i = 0; i < 3; i++) begin
            wr(8'h0D, AM[i]);
            words(6);
            for (int l = 0; l < 8; l++) begin
                a = rx_words[l*14 +: 14];
                hit = (a === AW[i]) || (a === BW[i]);
                check(hit, 1'b1);
            end
        end
        wr(8'h21, 8'h01);
        wr(8'h0D, 8'h0A);
        lanes(14'h003F, 5'h0C);
        wr(8'h0D, 8'h0C);
        lanes(14'h0A33, 5'h0C);
        wr(8'h21, 8'h00);
        wr(8'h14, 8'h07);
        lanes(14'h3985, 5'h0E);
        wr(8'h14, 8'h03);
        for (int i = 0; i < 2; i++) begin
            wr(8'h0D, PM[i] | PH[i]);
            words(6);
            a = rx_words[13:0];
            words(1);
            check(rx_words[13:0], a);
            check(rx_words[111:98], a);
            wr(8'h0D, PM[i]);
            words(6);
            a = rx_words[13:0];
            // two frames apart, so a repeated link word cannot mask the run
            words(2);
            check(rx_words[13:0] !== a, 1'b1);
        end
        wr(8'h0D, 8'h00);
        samp(14'h2000);
        stop_test();
    end
endmodule

bind aof_formatter aof_formatter_chk u_chk (.clk_in, .srst_in, .reg_wr_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .lvds_reduced_out,
    .drive_strength_out, .bit_clock_phase_out, .link_clk_in,
    .bit_clock_out_first, .bit_clock_out_second, .frame_clock_out_first,
    .frame_clock_out_second);
